// ===== core/espfm_pkg.sv
// Shared constants and types for the four-mode enhanced serial port
package espfm_pkg;

  // ==========================================================================
  // Register byte offsets
  localparam logic [4:0] ADDR_CONTROL = 5'h00;
  localparam logic [4:0] ADDR_DATA    = 5'h04;
  localparam logic [4:0] ADDR_SADDR   = 5'h08;
  localparam logic [4:0] ADDR_SMASK   = 5'h0c;
  localparam logic [4:0] ADDR_CONFIG  = 5'h10;

  // ==========================================================================
  // Reset values
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] DATA_RESET    = 8'h00;
  localparam logic [7:0] SADDR_RESET   = 8'h00;
  localparam logic [7:0] SMASK_RESET   = 8'h00;
  localparam logic [5:0] CONFIG_RESET  = 6'h00;

  // ==========================================================================
  // Control register fields
  localparam int CTL_MODE_HI = 7;
  localparam int CTL_MODE_LO = 6;
  localparam int CTL_FILTER  = 5;
  localparam int CTL_RX_EN   = 4;
  localparam int CTL_TX_B9   = 3;
  localparam int CTL_RX_B9   = 2;
  localparam int CTL_TX_DONE = 1;
  localparam int CTL_RX_DONE = 0;

  // ==========================================================================
  // Configuration register fields
  localparam int CFG_TX_BAUD_SEL = 0;
  localparam int CFG_RX_BAUD_SEL = 1;
  localparam int CFG_DOUBLER     = 2;
  localparam int CFG_TA_CLK_SEL  = 3;
  localparam int CFG_STATUS_VIEW = 4;
  localparam int CFG_IRQ_EN      = 5;

  // ==========================================================================
  // Cycle counts
  localparam logic [3:0] M0_LAST       = 4'hb;  // Shift clock is core clock / 12
  localparam logic [3:0] M0_HIGH_START = 4'h6;
  localparam logic [3:0] OS_LAST       = 4'hf;  // 16 samples per bit
  localparam logic [3:0] OS_CENTRE     = 4'h7;
  localparam logic [3:0] M0_BITS       = 4'h8;
  localparam logic [3:0] MODE1_BITS    = 4'ha;
  localparam logic [3:0] MODE23_BITS   = 4'hb;

  typedef enum logic [1:0] {
    ESPFM_MODE_SYNC  = 2'b00,
    ESPFM_MODE_8BIT  = 2'b01,
    ESPFM_MODE_9FIX  = 2'b10,
    ESPFM_MODE_9VAR  = 2'b11
  } espfm_mode_t;

  typedef enum logic [1:0] {
    ESPFM_RX_IDLE  = 2'b00,
    ESPFM_RX_START = 2'b01,
    ESPFM_RX_DATA  = 2'b10,
    ESPFM_RX_STOP  = 2'b11
  } espfm_rx_state_t;

endpackage

// ===== core/espfm_serial_port.sv
// Four-mode enhanced serial port with Avalon-MM register slave
//
// Chosen here: the address map and register access over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none

module espfm_serial_port (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rst_b,
  // Avalon-MM slave
  input  wire logic [4:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  // Timer overflow pulses and timer steering
  input  wire logic        timer_a_overflow,
  input  wire logic        timer_b_overflow,
  output logic             timer_b_force_baud,
  output logic             timer_a_clock_select,
  // Serial pins
  output logic             serial_out_pin,
  input  wire logic        serial_in_pin_in,
  output logic             serial_in_pin_out,
  output logic             serial_in_pin_oe,
  // Interrupt request
  output logic             serial_irq
);

  // ==========================================================================
  // Register state
  logic [7:0]  ctl_reg;
  logic [7:0]  rx_buf_reg;
  logic [7:0]  saddr_reg;
  logic [7:0]  smask_reg;
  logic [5:0]  cfg_reg;
  logic        fe_reg;
  logic        ovr_reg;
  logic        col_reg;
  logic        unread_reg;
  logic        ack_reg;
  logic [31:0] rdata_reg;

  logic        req;
  logic        acc;
  logic        wr_ctl;
  logic        wr_data;
  logic        rd_data;
  logic [1:0]  mode;
  logic        stat_view;
  logic [7:0]  ctl_view;

  assign mode      = ctl_reg[espfm_pkg::CTL_MODE_HI:espfm_pkg::CTL_MODE_LO];
  assign stat_view = cfg_reg[espfm_pkg::CFG_STATUS_VIEW];
  assign req       = avs_read | avs_write;
  assign acc       = req & ack_reg;
  assign wr_ctl    = acc & avs_write & (avs_address == espfm_pkg::ADDR_CONTROL);
  assign wr_data   = acc & avs_write & (avs_address == espfm_pkg::ADDR_DATA);
  assign rd_data   = acc & avs_read & (avs_address == espfm_pkg::ADDR_DATA);

  // One wait state on every access, then the answer
  assign avs_waitrequest = req & ~ack_reg;
  assign avs_readdata    = rdata_reg;

  assign ctl_view = stat_view ? {fe_reg, ovr_reg, col_reg, ctl_reg[4:0]} : ctl_reg;

  function automatic logic addr_match(input logic [7:0] a, input logic [7:0] sa, input logic [7:0] sm);
    logic [7:0] bcast;
    bcast = sa | sm;
    addr_match = (((a ^ sa) & sm) == 8'h00)
               | (((a ^ bcast) & bcast) == 8'h00);
  endfunction

  always_ff @(posedge clock)
  begin
    if (!rst_b)
      ack_reg <= 1'b0;
    else
      ack_reg <= req & ~ack_reg;
  end

  always_ff @(posedge clock)
  begin
    if (!rst_b)
      rdata_reg <= 32'h0000_0000;
    else if (avs_read && !ack_reg)
    begin
      if (avs_address == espfm_pkg::ADDR_CONTROL)
        rdata_reg <= {24'h00_0000, ctl_view};
      else if (avs_address == espfm_pkg::ADDR_DATA)
        rdata_reg <= {24'h00_0000, rx_buf_reg};
      else if (avs_address == espfm_pkg::ADDR_SADDR)
        rdata_reg <= {24'h00_0000, saddr_reg};
      else if (avs_address == espfm_pkg::ADDR_SMASK)
        rdata_reg <= {24'h00_0000, smask_reg};
      else if (avs_address == espfm_pkg::ADDR_CONFIG)
        rdata_reg <= {26'h0, cfg_reg};
      else
        rdata_reg <= 32'h0000_0000;
    end
  end

  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      saddr_reg <= espfm_pkg::SADDR_RESET;
      smask_reg <= espfm_pkg::SMASK_RESET;
      cfg_reg   <= espfm_pkg::CONFIG_RESET;
    end
    else if (acc && avs_write)
    begin
      if (avs_address == espfm_pkg::ADDR_SADDR)
        saddr_reg <= avs_writedata[7:0];
      else if (avs_address == espfm_pkg::ADDR_SMASK)
        smask_reg <= avs_writedata[7:0];
      else if (avs_address == espfm_pkg::ADDR_CONFIG)
        cfg_reg <= avs_writedata[5:0];
    end
  end

  assign timer_a_clock_select = cfg_reg[espfm_pkg::CFG_TA_CLK_SEL];
  assign timer_b_force_baud   = cfg_reg[espfm_pkg::CFG_TX_BAUD_SEL] | cfg_reg[espfm_pkg::CFG_RX_BAUD_SEL];
  assign serial_irq = cfg_reg[espfm_pkg::CFG_IRQ_EN]
                    & (ctl_reg[espfm_pkg::CTL_TX_DONE] | ctl_reg[espfm_pkg::CTL_RX_DONE]);

  // ==========================================================================
  // Oversampling ticks, 16 per bit
  logic [1:0] m2_div_reg;
  logic       ta_half_reg;
  logic       m2_tick;
  logic       ta_tick;
  logic       tx_os_tick;
  logic       rx_os_tick;

  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      m2_div_reg  <= 2'h0;
      ta_half_reg <= 1'b0;
    end
    else
    begin
      m2_div_reg <= m2_div_reg + 2'h1;
      if (timer_a_overflow)
        ta_half_reg <= ~ta_half_reg;
    end
  end

  // Mode 2 bit is 64 or 32 core clocks: a tick every 4 or 2 clocks
  assign m2_tick = m2_div_reg[0] & (cfg_reg[espfm_pkg::CFG_DOUBLER] | m2_div_reg[1]);
  // 8-bit timer: bit is 32 overflows, 16 with doubler
  assign ta_tick = timer_a_overflow & (cfg_reg[espfm_pkg::CFG_DOUBLER] | ta_half_reg);
  // 16-bit timer runs at core clock / 2, so 16 overflows make a bit
  assign tx_os_tick = (mode == espfm_pkg::ESPFM_MODE_9FIX) ? m2_tick
                    : (cfg_reg[espfm_pkg::CFG_TX_BAUD_SEL] ? timer_b_overflow : ta_tick);
  assign rx_os_tick = (mode == espfm_pkg::ESPFM_MODE_9FIX) ? m2_tick
                    : (cfg_reg[espfm_pkg::CFG_RX_BAUD_SEL] ? timer_b_overflow : ta_tick);

  // ==========================================================================
  // Transmitter and mode 0 shift engine
  logic [10:0] tx_shift_reg;
  logic        tx_active_reg;
  logic [3:0]  tx_bit_reg;
  logic [3:0]  tx_os_reg;
  logic        m0_rx_reg;
  logic        m0_fin_reg;
  logic [7:0]  m0_rx_shift_reg;
  logic        sout_reg;
  logic        tx_set_done;
  logic        rx_set_done;
  logic        rx_load;
  logic [7:0]  rx_load_data;
  logic        rx_load_b9;
  logic        is_sync;
  logic [3:0]  tx_nbits;
  logic        m0_rx_start;

  assign is_sync     = (mode == espfm_pkg::ESPFM_MODE_SYNC);
  assign tx_nbits    = (mode == espfm_pkg::ESPFM_MODE_8BIT) ? espfm_pkg::MODE1_BITS : espfm_pkg::MODE23_BITS;
  assign m0_rx_start = is_sync & ~tx_active_reg & ~m0_fin_reg & ~wr_data
                     & ctl_reg[espfm_pkg::CTL_RX_EN] & ~ctl_reg[espfm_pkg::CTL_RX_DONE];

  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      tx_shift_reg    <= 11'h7ff;
      tx_active_reg   <= 1'b0;
      tx_bit_reg      <= 4'h0;
      tx_os_reg       <= 4'h0;
      m0_rx_reg       <= 1'b0;
      m0_rx_shift_reg <= 8'h00;
    end
    else if (!tx_active_reg)
    begin
      tx_bit_reg <= 4'h0;
      tx_os_reg  <= 4'h0;
      if (wr_data)
      begin
        tx_active_reg <= 1'b1;
        m0_rx_reg     <= 1'b0;
        if (is_sync)
          tx_shift_reg <= {3'h7, avs_writedata[7:0]};
        else if (mode == espfm_pkg::ESPFM_MODE_8BIT)
          tx_shift_reg <= {2'h3, avs_writedata[7:0], 1'b0};
        else
          tx_shift_reg <= {1'b1, ctl_reg[espfm_pkg::CTL_TX_B9], avs_writedata[7:0], 1'b0};
      end
      else if (m0_rx_start)
      begin
        tx_active_reg <= 1'b1;
        m0_rx_reg     <= 1'b1;
        tx_shift_reg  <= 11'h7ff;
      end
    end
    else if (is_sync)
    begin
      tx_os_reg <= (tx_os_reg == espfm_pkg::M0_LAST) ? 4'h0 : tx_os_reg + 4'h1;
      if (m0_rx_reg && tx_os_reg == espfm_pkg::M0_HIGH_START)
        m0_rx_shift_reg <= {serial_in_pin_in, m0_rx_shift_reg[7:1]};
      if (tx_os_reg == espfm_pkg::M0_LAST)
      begin
        tx_shift_reg <= {1'b1, tx_shift_reg[10:1]};
        tx_bit_reg   <= tx_bit_reg + 4'h1;
        if (tx_bit_reg == espfm_pkg::M0_BITS - 4'h1)
          tx_active_reg <= 1'b0;
      end
    end
    else if (tx_os_tick)
    begin
      tx_os_reg <= tx_os_reg + 4'h1;
      if (tx_os_reg == espfm_pkg::OS_LAST)
      begin
        tx_shift_reg <= {1'b1, tx_shift_reg[10:1]};
        tx_bit_reg   <= tx_bit_reg + 4'h1;
        if (tx_bit_reg == tx_nbits - 4'h1)
          tx_active_reg <= 1'b0;
      end
    end
  end

  assign tx_set_done = tx_active_reg & ~m0_rx_reg &
                       (is_sync ? (tx_os_reg == espfm_pkg::M0_LAST && tx_bit_reg == espfm_pkg::M0_BITS - 4'h1)
                                : (tx_os_tick && tx_os_reg == espfm_pkg::OS_LAST
                                   && tx_bit_reg == tx_nbits - 4'h2));

  // Receive completes one cycle after the eighth bit
  always_ff @(posedge clock)
  begin
    if (!rst_b)
      m0_fin_reg <= 1'b0;
    else
      m0_fin_reg <= tx_active_reg & m0_rx_reg & is_sync
                  & (tx_os_reg == espfm_pkg::M0_LAST) & (tx_bit_reg == espfm_pkg::M0_BITS - 4'h1);
  end

  // Shift clock low then high; async line idles high
  always_ff @(posedge clock)
  begin
    if (!rst_b)
      sout_reg <= 1'b1;
    else if (is_sync)
      sout_reg <= ~(tx_active_reg && tx_os_reg < espfm_pkg::M0_HIGH_START - 4'h1)
                | (tx_active_reg && tx_os_reg == espfm_pkg::M0_LAST);
    else
      sout_reg <= tx_shift_reg[0];
  end

  assign serial_out_pin    = sout_reg;
  assign serial_in_pin_out = 1'b0;
  // Open drain: only pull low, an external pull-up gives the ones
  assign serial_in_pin_oe  = is_sync & tx_active_reg & ~m0_rx_reg & ~tx_shift_reg[0];

  // ==========================================================================
  // Asynchronous receiver
  espfm_pkg::espfm_rx_state_t rx_state_reg;
  logic [3:0] rx_os_reg;
  logic [3:0] rx_bit_reg;
  logic [8:0] rx_shift_reg;
  logic       rx_prev_reg;
  logic       rx_stop_now;
  logic       rx_accept;
  logic [3:0] rx_ndata;

  assign rx_ndata    = (mode == espfm_pkg::ESPFM_MODE_8BIT) ? 4'h8 : 4'h9;
  // Last data sample was at a bit centre, so 16 more ticks land on the stop centre
  assign rx_stop_now = (rx_state_reg == espfm_pkg::ESPFM_RX_STOP) & rx_os_tick & (rx_os_reg == espfm_pkg::OS_LAST);
  // Mode 1: stop bit must be high when filtering; modes 2,3: ninth bit and address
  assign rx_accept = ~ctl_reg[espfm_pkg::CTL_RX_DONE] & (~ctl_reg[espfm_pkg::CTL_FILTER] |
                     ((mode == espfm_pkg::ESPFM_MODE_8BIT) ? serial_in_pin_in
                      : (rx_shift_reg[8] & addr_match(rx_shift_reg[7:0], saddr_reg, smask_reg))));

  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      rx_state_reg <= espfm_pkg::ESPFM_RX_IDLE;
      rx_os_reg    <= 4'h0;
      rx_bit_reg   <= 4'h0;
      rx_shift_reg <= 9'h000;
      rx_prev_reg  <= 1'b1;
    end
    else
    begin
      rx_prev_reg <= serial_in_pin_in;
      if (is_sync || !ctl_reg[espfm_pkg::CTL_RX_EN])
        rx_state_reg <= espfm_pkg::ESPFM_RX_IDLE;
      else
      case (rx_state_reg)
        espfm_pkg::ESPFM_RX_IDLE:
          if (rx_prev_reg && !serial_in_pin_in)
          begin
            rx_state_reg <= espfm_pkg::ESPFM_RX_START;
            rx_os_reg    <= 4'h0;
            rx_bit_reg   <= 4'h0;
          end
        espfm_pkg::ESPFM_RX_START:
          if (rx_os_tick)
          begin
            rx_os_reg <= rx_os_reg + 4'h1;
            // A start bit that is high again at its centre was a glitch
            if (rx_os_reg == espfm_pkg::OS_CENTRE)
            begin
              rx_os_reg    <= 4'h0;
              rx_state_reg <= serial_in_pin_in ? espfm_pkg::ESPFM_RX_IDLE : espfm_pkg::ESPFM_RX_DATA;
            end
          end
        espfm_pkg::ESPFM_RX_DATA:
          if (rx_os_tick)
          begin
            rx_os_reg <= rx_os_reg + 4'h1;
            if (rx_os_reg == espfm_pkg::OS_LAST)
            begin
              rx_shift_reg <= (mode == espfm_pkg::ESPFM_MODE_8BIT) ? {1'b0, serial_in_pin_in, rx_shift_reg[7:1]}
                                                                    : {serial_in_pin_in, rx_shift_reg[8:1]};
              rx_bit_reg <= rx_bit_reg + 4'h1;
              if (rx_bit_reg == rx_ndata - 4'h1)
                rx_state_reg <= espfm_pkg::ESPFM_RX_STOP;
            end
          end
        espfm_pkg::ESPFM_RX_STOP:
          if (rx_os_tick)
          begin
            rx_os_reg <= rx_os_reg + 4'h1;
            if (rx_os_reg == espfm_pkg::OS_LAST)
              rx_state_reg <= espfm_pkg::ESPFM_RX_IDLE;
          end
        default:
          rx_state_reg <= espfm_pkg::ESPFM_RX_IDLE;
      endcase
    end
  end

  assign rx_load      = m0_fin_reg | (rx_stop_now & rx_accept);
  assign rx_load_data = m0_fin_reg ? m0_rx_shift_reg : rx_shift_reg[7:0];
  // Mode 1 keeps the stop bit, modes 2,3 the ninth bit
  assign rx_load_b9   = (mode == espfm_pkg::ESPFM_MODE_8BIT) ? serial_in_pin_in : rx_shift_reg[8];
  assign rx_set_done  = rx_load;

  // ==========================================================================
  // Holding register, control register and status flags
  always_ff @(posedge clock)
  begin
    if (!rst_b)
      rx_buf_reg <= espfm_pkg::DATA_RESET;
    else if (rx_load)
      rx_buf_reg <= rx_load_data;
  end

  always_ff @(posedge clock)
  begin
    if (!rst_b)
      unread_reg <= 1'b0;
    else if (rx_load)
      unread_reg <= 1'b1;
    else if (rd_data)
      unread_reg <= 1'b0;
  end

  // Hardware sets win over a software clear in the same cycle
  always_ff @(posedge clock)
  begin
    if (!rst_b)
      ctl_reg <= espfm_pkg::CONTROL_RESET;
    else
    begin
      if (wr_ctl)
      begin
        ctl_reg[4:0] <= avs_writedata[4:0];
        if (!stat_view)
          ctl_reg[7:5] <= avs_writedata[7:5];
      end
      if (rx_load && !m0_fin_reg)
        ctl_reg[espfm_pkg::CTL_RX_B9] <= rx_load_b9;
      if (tx_set_done)
        ctl_reg[espfm_pkg::CTL_TX_DONE] <= 1'b1;
      if (rx_set_done)
        ctl_reg[espfm_pkg::CTL_RX_DONE] <= 1'b1;
    end
  end

  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      fe_reg  <= 1'b0;
      ovr_reg <= 1'b0;
      col_reg <= 1'b0;
    end
    else
    begin
      if (wr_ctl && stat_view)
      begin
        fe_reg  <= avs_writedata[7];
        ovr_reg <= avs_writedata[6];
        col_reg <= avs_writedata[5];
      end
      if (rx_stop_now && !serial_in_pin_in)
        fe_reg <= 1'b1;
      if (rx_load && unread_reg && !is_sync)
        ovr_reg <= 1'b1;
      if (wr_data && tx_active_reg)
        col_reg <= 1'b1;
    end
  end

  // ==========================================================================
  // Checks
  a_bus_one_wait: assert property (@(posedge clock) disable iff (!rst_b)
    ($rose(req) && !ack_reg) |-> avs_waitrequest ##1 !avs_waitrequest)
    else $error("bus answer not after one wait state");
  a_data_read_rx: assert property (@(posedge clock) disable iff (!rst_b)
    (rd_data && !$past(rx_load)) |-> avs_readdata[7:0] == rx_buf_reg)
    else $error("data read does not return receive holding register");
  a_tx_done_holds: assert property (@(posedge clock) disable iff (!rst_b)
    (ctl_reg[espfm_pkg::CTL_TX_DONE] && !wr_ctl) |=> ctl_reg[espfm_pkg::CTL_TX_DONE])
    else $error("transmit done cleared without a software write");
  a_rx_buf_held: assert property (@(posedge clock) disable iff (!rst_b)
    (ctl_reg[espfm_pkg::CTL_RX_DONE] && !wr_ctl && !m0_fin_reg) |=> $stable(rx_buf_reg))
    else $error("holding register overwritten while receive done set");
  a_m0_clk_period: assert property (@(posedge clock) disable iff (!rst_b)
    ($rose(sout_reg) && is_sync && tx_active_reg && tx_bit_reg < 4'h7) |-> ##12 $rose(sout_reg))
    else $error("mode 0 shift clock period is not 12 cycles");
  a_pin_open_drain: assert property (@(posedge clock) disable iff (!rst_b)
    serial_in_pin_oe |-> (is_sync && !serial_in_pin_out))
    else $error("data pin driven high or outside mode 0");
  a_async_start: assert property (@(posedge clock) disable iff (!rst_b)
    (wr_data && !tx_active_reg && !is_sync) |=> ##1 !serial_out_pin)
    else $error("async write did not send a start bit");
  a_irq_follows: assert property (@(posedge clock) disable iff (!rst_b)
    ($rose(ctl_reg[espfm_pkg::CTL_RX_DONE]) && cfg_reg[espfm_pkg::CFG_IRQ_EN]) |-> serial_irq)
    else $error("interrupt missing after receive done");
  a_collision_set: assert property (@(posedge clock) disable iff (!rst_b)
    (wr_data && tx_active_reg) |=> col_reg)
    else $error("collision flag not set on busy write");

endmodule

`default_nettype wire

// ===== testbench/espfm_peer.sv
// Far-side serial peer model for the serial pins, asynchronous and mode 0
`timescale 1ns/1ps
`default_nettype none
module espfm_peer #(parameter int BIT_CLKS = 32) (
  // Clock
  input  wire logic clock,
  // Line pair
  input  wire logic line_in,
  output var  logic line_out
);
  // ====================
  // Frame tasks
  // Idle line rests at the mark level
  initial line_out = 1'b1;
  task automatic send(input logic [7:0] d, input logic nine);
    logic [10:0] f;
    f = {1'b1, nine, d, 1'b0};
    for (int i = 0; i < 11; i++)
    begin
      line_out <= f[i];
      repeat (BIT_CLKS) @(posedge clock);
    end
  endtask
  // Mode 0 slave: the next bit goes out after each falling shift-clock edge
  task automatic shift_out(input logic [7:0] d);
    int   i, n;
    logic prev;
    i = 0;
    prev = 1'b1;
    for (n = 0; n < 400 && i < 8; n++)
    begin
      @(posedge clock);
      if (prev && !line_in)
      begin
        line_out <= d[i];
        i++;
      end
      prev = line_in;
    end
    // Hold the last bit past its sampling point before releasing the wire
    repeat (12) @(posedge clock);
    line_out <= 1'b1;
  endtask
  // Start is seen late by a few clocks at most, so half a bit still lands near each centre
  task automatic capture(output logic [10:0] f, output logic ok);
    for (int n = 0; n < 300 && line_in; n++)
      @(posedge clock);
    ok = !line_in;
    repeat (BIT_CLKS / 2) @(posedge clock);
    for (int i = 0; i < 11; i++)
    begin
      f[i] = line_in;
      repeat (BIT_CLKS) @(posedge clock);
    end
  endtask
endmodule
`default_nettype wire

// ===== testbench/espfm_serial_port_tb.sv
// Self-checking bench for the four-mode serial port
`timescale 1ns/1ps
`default_nettype none
module espfm_serial_port_tb;
  localparam logic [4:0] CTL = espfm_pkg::ADDR_CONTROL;
  localparam logic [4:0] DAT = espfm_pkg::ADDR_DATA;
  localparam logic [4:0] CFG = espfm_pkg::ADDR_CONFIG;
  logic        clock, rx_line, tx_line, pin_out, pin_oe, irq, wait_req;
  logic        force_baud, ta_sel, ovf = 1'b0;
  logic        rst_b = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
  logic [4:0]  avs_address = '0;
  logic [31:0] avs_writedata = '0, avs_readdata, rd;
  int          err_count = 0, tests_run = 0;
  // Open-drain data wire: device only ever pulls low
  wire logic   pin_wire = pin_oe ? 1'b0 : rx_line;
  // ====================
  // Design and peer
  espfm_serial_port dut_u (.clock(clock), .rst_b(rst_b), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(wait_req), .timer_a_overflow(ovf), .timer_b_overflow(ovf), .timer_b_force_baud(force_baud),
    .timer_a_clock_select(ta_sel), .serial_out_pin(tx_line), .serial_in_pin_in(pin_wire),
    .serial_in_pin_out(pin_out), .serial_in_pin_oe(pin_oe), .serial_irq(irq));
  espfm_peer peer_u (.clock(clock), .line_in(tx_line), .line_out(rx_line));
  initial
  begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  // Both timers overflow every second clock: 32 clocks a bit, as the peer expects
  always @(posedge clock)
    ovf <= ~ovf;
  // ====================
  // Shared tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      err_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic finish_test();
    $display("mismatches %0d of %0d checks", err_count, tests_run);
    if (err_count == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic bus(input logic wr, input logic [4:0] a, input logic [7:0] d);
    int n;
    @(posedge clock);
    avs_write     <= wr;
    avs_read      <= !wr;
    avs_address   <= a;
    avs_writedata <= {24'h0, d};
    @(posedge clock);
    for (n = 0; n < 20 && wait_req; n++)
      @(posedge clock);
    check(wait_req, 1'b0);
    if (wait_req)
      finish_test();
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
  endtask
  // ====================
  // Scenarios
  // Second write lands mid-frame and must be dropped
  task automatic async_tx();
    logic [10:0] f;
    logic        ok;
    bus(1, CTL, 8'h88);
    bus(1, DAT, 8'ha5);
    bus(1, DAT, 8'h11);
    peer_u.capture(f, ok);
    check({ok, f}, {1'b1, 11'h74a});
    bus(0, CTL, 8'h00);
    check(rd, 32'h8a);
    check(irq, 1'b1);
    bus(1, CFG, 8'h34);
    bus(0, CTL, 8'h00);
    check(rd, 32'h2a);
    bus(1, CFG, 8'h24);
    bus(1, CTL, 8'h88);
    @(posedge clock);
    check(irq, 1'b0);
  endtask
  // Entry: control value, ninth bit, data byte
  task automatic receive_filter();
    logic [16:0] tbl [5] = '{17'h1213c, 17'h16146, 17'h16025, 17'h16125, 17'h161ff};
    logic [4:0]  acc = 5'b11001;
    bus(1, espfm_pkg::ADDR_SADDR, 8'h35);
    bus(1, espfm_pkg::ADDR_SMASK, 8'h0f);
    for (int i = 0; i < 5; i++)
    begin
      bus(1, CTL, tbl[i][16:9]);
      @(posedge clock);
      peer_u.send(tbl[i][7:0], tbl[i][8]);
      check(irq, acc[i]);
      if (acc[i])
      begin
        bus(0, DAT, 8'h00);
        check(rd, {24'h0, tbl[i][7:0]});
        bus(0, CTL, 8'h00);
        check(rd[2], tbl[i][8]);
      end
    end
  endtask
  // Data bit is taken at each rising edge of the shift clock
  task automatic sync_tx();
    logic [7:0] got;
    logic       prev;
    int         gap, n;
    bus(1, CTL, 8'h00);
    bus(1, DAT, 8'h96);
    prev = 1'b1;
    gap = 0;
    n = 0;
    for (int c = 0; c < 200 && n < 8; c++)
    begin
      @(posedge clock);
      gap++;
      if (tx_line && !prev)
      begin
        got[n] = pin_wire;
        if (n > 0)
          check(gap, 12);
        gap = 0;
        n++;
      end
      prev = tx_line;
    end
    check(got, 8'h96);
    check(pin_out, 1'b0);
    repeat (14) @(posedge clock);
    bus(0, CTL, 8'h00);
    check(rd, 32'h02);
  endtask
  // Modes 1 and 3 on timer baud; collision flag is still set from async_tx
  task automatic timer_modes();
    logic [10:0] f;
    logic        ok;
    bus(1, CFG, 8'h2d);
    bus(1, CTL, 8'h70);
    check({force_baud, ta_sel}, 2'b11);
    bus(1, DAT, 8'h3c);
    peer_u.capture(f, ok);
    check({ok, f}, {1'b1, 11'h678});
    bus(0, CTL, 8'h00);
    check(rd, 32'h72);
    bus(1, CTL, 8'h70);
    peer_u.send(8'hc3, 1'b1);
    check(irq, 1'b1);
    bus(1, CTL, 8'h70);
    peer_u.send(8'h5a, 1'b0);
    check(irq, 1'b0);
    peer_u.send(8'he7, 1'b1);
    bus(0, DAT, 8'h00);
    check(rd, 32'he7);
    bus(0, CTL, 8'h00);
    check(rd, 32'h75);
    bus(1, CTL, 8'hd0);
    peer_u.send(8'h9e, 1'b0);
    bus(0, CTL, 8'h00);
    check(rd, 32'hd1);
    bus(1, CFG, 8'h3d);
    bus(0, CTL, 8'h00);
    check(rd, 32'hf1);
    bus(1, CFG, 8'h24);
  endtask
  task automatic sync_rx();
    bus(1, CTL, 8'h10);
    peer_u.shift_out(8'h5c);
    bus(0, DAT, 8'h00);
    check(rd, 32'h5c);
    bus(0, CTL, 8'h00);
    check(rd, 32'h11);
    check(irq, 1'b1);
  endtask
  initial
  begin
    repeat (6) @(posedge clock);
    rst_b <= 1'b1;
    bus(0, CTL, 8'h00);
    check(rd, {24'h0, espfm_pkg::CONTROL_RESET});
    bus(0, 5'h14, 8'h00);
    check(rd, 32'h0);
    bus(1, CFG, 8'h24);
    async_tx();
    receive_filter();
    timer_modes();
    sync_tx();
    sync_rx();
    finish_test();
  end
endmodule
`default_nettype wire
